/* include/atc_pkg.sv */
// How it works
// - a tune request pulse energizes the tune relay and wakes the controller
// - tune hold stays high through the tune cycle, drops when it ends
// - phase and magnitude both in window, with vswr low and rf present, release pad and tune relays
// - after a good tune all bus activity stops and the controller sleeps
// - asleep, button, channel change or vswr fault wakes the controller
// - untunable load or unit failure during a tune raises coupler fault and selects bypass
// - peripheral selects are decoded from upper address byte
// - channel buffer drives the data bus only with its select high and read low
// - the channel port is read periodically to sample the channel code
// - address latch enable pulse captures and holds the low address byte
// - program memory uses latched low byte plus four upper bits on read
// - impedance flags active low, both low illegal, both high in window
// - phase flags active low, both low illegal, both high in window
// - in window during a tune, vswr low and rf present means tune ready
// - each channel stores relay settings with a valid marker code
// - channel change wakes, recalls stored settings, drives network, sleeps
// - ten second timer from each tune command aborts with fault
// - high vswr fault input wakes a sleeping controller into a tune
// - pad switched in on vswr fault while keyed, out on good tune
package atc_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int TUNE_LIMIT_S = 10;
    localparam longint TUNE_LIMIT_CYC = longint'(TUNE_LIMIT_S) * CLK_HZ;
    localparam int SAMPLE_PERIOD_CYC = 1024;
    localparam int STEP_CYC = 16;
    // upper address byte page codes
    localparam logic [7:0] PG_PROG = 8'h00;
    localparam logic [7:0] PG_RAMIO = 8'h20;
    localparam logic [7:0] PG_CHMEM = 8'h40;
    localparam logic [7:0] PG_OUTLAT = 8'h60;
    localparam logic [7:0] PG_CHUPD = 8'h80;
    localparam logic [7:0] PG_CHIN = 8'ha0;
    localparam logic [7:0] VALID_MARK = 8'ha5;
    localparam logic [15:0] RELAY_RESET = 16'h0000;
    typedef enum logic [2:0] {
        ST_SLEEP = 3'b000,
        ST_TUNE = 3'b001,
        ST_RECALL = 3'b010,
        ST_STORE = 3'b011,
        ST_FAULT = 3'b100
    } atc_state_e;
endpackage : atc_pkg

/* hdl/atc_window.sv */
`timescale 1ns/1ps
module atc_window
    import atc_pkg::*;
(
    // active-low comparator pair
    input wire logic aboveN,
    input wire logic belowN,
    // decoded
    output logic inWindow,
    output logic above,
    output logic below
);
    always_comb begin
        // both low cannot happen physically; treat as out of window
        inWindow = aboveN & belowN;
        above = ~aboveN & belowN;
        below = aboveN & ~belowN;
    end
endmodule : atc_window

/* hdl/atc_addr_bus.sv */
`timescale 1ns/1ps
module atc_addr_bus
    import atc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstSync_n,
    // processor bus
    input wire logic ale,
    input wire logic [7:0] muxedAddrData,
    input wire logic [7:0] addrHigh,
    input wire logic readStrobe_n,
    // decoded
    output logic [7:0] latchedLow,
    output logic [11:0] progAddr,
    output logic progOe,
    output logic selProg,
    output logic selRamIo,
    output logic selChMem,
    output logic selOutLatch,
    output logic selChUpdate,
    output logic channel_port_select,
    output logic chanDriveEn
);
    logic [7:0] next_latchedLow;
    always_comb begin
        next_latchedLow = ale ? muxedAddrData : latchedLow;
    end
    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            latchedLow <= 8'h00;
        end else begin
            latchedLow <= next_latchedLow;
        end
    end
    always_comb begin
        selProg = (addrHigh[7:5] == PG_PROG[7:5]);
        selRamIo = (addrHigh[7:5] == PG_RAMIO[7:5]);
        selChMem = (addrHigh[7:5] == PG_CHMEM[7:5]);
        selOutLatch = (addrHigh[7:5] == PG_OUTLAT[7:5]);
        selChUpdate = (addrHigh[7:5] == PG_CHUPD[7:5]);
        channel_port_select = (addrHigh[7:5] == PG_CHIN[7:5]);
        progAddr = {addrHigh[3:0], latchedLow};
        progOe = selProg & ~readStrobe_n;
        chanDriveEn = channel_port_select & ~readStrobe_n;
    end
    latch_hold_a: assert property (@(posedge core_clk) disable iff (!rstSync_n)
        !ale |=> latchedLow == $past(latchedLow)) else $error("address latch drifted");
    chan_drive_a: assert property (@(posedge core_clk) disable iff (!rstSync_n)
        chanDriveEn |-> channel_port_select && !readStrobe_n) else $error("bad chan drive");
endmodule : atc_addr_bus

/* hdl/atc_core.sv */
`timescale 1ns/1ps
module atc_core
    import atc_pkg::*;
#(
    parameter longint TUNE_LIMIT = TUNE_LIMIT_CYC,
    parameter int CHANNELS = 128
)(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // transceiver side
    input wire logic tuneRequest,
    input wire logic front_tune_button,
    input wire logic [7:0] channelLines_n,
    input wire logic txKeyed,
    input wire logic rfPresent_n,
    // comparators
    input wire logic impedance_high_n,
    input wire logic impedance_low_n,
    input wire logic phaseHigh_n,
    input wire logic phaseLow_n,
    input wire logic vswrFault,
    input wire logic unitFailure,
    // tuning network stepping
    input wire logic [15:0] stepRelays,
    // processor bus
    input wire logic ale,
    input wire logic [7:0] muxedAddrDataIn,
    input wire logic [7:0] addrHigh,
    input wire logic readStrobe_n,
    output logic [7:0] muxedAddrDataOut,
    output logic muxedAddrDataOe,
    output logic [11:0] progAddr,
    output logic progOe,
    output logic [5:0] periphSelect,
    // outputs
    output logic tuneHold,
    output logic padRelay,
    output logic coupler_fault_flag,
    output logic bypass,
    output logic tuneReady,
    output logic busActive,
    output logic [15:0] relayDrive
);
    logic rstMeta_n;
    logic rstSync_n;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_n <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta_n <= 1'b1;
            rstSync_n <= rstMeta_n;
        end
    end

    logic magIn, phIn;
    // direction flags unused: stepping pattern comes from stepRelays
    atc_window u_mag (
        .aboveN(impedance_high_n),
        .belowN(impedance_low_n),
        .inWindow(magIn),
        .above(),
        .below()
    );
    atc_window u_ph (
        .aboveN(phaseHigh_n),
        .belowN(phaseLow_n),
        .inWindow(phIn),
        .above(),
        .below()
    );

    logic [7:0] latchedLow;
    logic chanDriveEn;
    atc_addr_bus u_bus (
        .core_clk(core_clk),
        .rstSync_n(rstSync_n),
        .ale(ale),
        .muxedAddrData(muxedAddrDataIn),
        .addrHigh(addrHigh),
        .readStrobe_n(readStrobe_n),
        .latchedLow(latchedLow),
        .progAddr(progAddr),
        .progOe(progOe),
        .selProg(periphSelect[0]),
        .selRamIo(periphSelect[1]),
        .selChMem(periphSelect[2]),
        .selOutLatch(periphSelect[3]),
        .selChUpdate(periphSelect[4]),
        .channel_port_select(periphSelect[5]),
        .chanDriveEn(chanDriveEn)
    );

    // channel store: settings plus marker per channel
    logic [15:0] chSettings [CHANNELS];
    logic [7:0] chMarker [CHANNELS];

    atc_state_e state, next_state;
    logic [35:0] tuneTimer, next_tuneTimer;
    logic [9:0] sampleCnt, next_sampleCnt;
    logic [3:0] stepCnt, next_stepCnt;
    logic [7:0] chanSample, next_chanSample;
    logic [7:0] chanIndex;
    logic next_tuneHold, next_padRelay, next_fault, next_bypass, next_ready;
    logic [15:0] next_relayDrive;
    logic [7:0] next_busOut;
    logic storeEn, tuneWake, chanChange, timeout, goodTune;

    // inverted code: all ones is channel 00; value taken as binary index
    assign chanIndex = ~chanSample;
    assign tuneWake = tuneRequest | front_tune_button | vswrFault;
    assign chanChange = (sampleCnt == 10'(SAMPLE_PERIOD_CYC - 1))
        && (channelLines_n != chanSample);
    assign timeout = (tuneTimer == 36'(TUNE_LIMIT - 1));
    // rf must be present (low) for the tune to count
    assign goodTune = magIn & phIn & vswrFault == 1'b0 & ~rfPresent_n;

    always_comb begin
        next_state = state;
        next_tuneTimer = tuneTimer;
        next_sampleCnt = sampleCnt + 10'h001;
        next_stepCnt = stepCnt;
        next_chanSample = chanSample;
        next_tuneHold = tuneHold;
        next_padRelay = padRelay;
        next_fault = coupler_fault_flag;
        next_bypass = bypass;
        next_ready = tuneReady;
        next_relayDrive = relayDrive;
        storeEn = 1'b0;
        if (chanChange) begin
            next_chanSample = channelLines_n;
        end
        if (vswrFault && txKeyed) begin
            next_padRelay = 1'b1;
        end
        case (state)
            ST_SLEEP: begin
                // bus quiet while asleep
                if (tuneWake) begin
                    next_state = ST_TUNE;
                    next_tuneHold = 1'b1;
                    next_tuneTimer = 36'h0;
                    next_fault = 1'b0;
                    next_bypass = 1'b0;
                    next_ready = 1'b0;
                end else if (chanChange) begin
                    next_state = ST_RECALL;
                end
            end
            ST_TUNE: begin
                next_tuneHold = 1'b1;
                next_tuneTimer = tuneTimer + 36'h1;
                next_stepCnt = stepCnt + 4'h1;
                if (tuneRequest || front_tune_button) begin
                    next_tuneTimer = 36'h0;
                end else if (timeout || unitFailure) begin
                    next_state = ST_FAULT;
                end else if (goodTune && vswrFault == 1'b0) begin
                    next_state = ST_STORE;
                end else if (stepCnt == 4'(STEP_CYC - 1) && !rfPresent_n) begin
                    // rf present: network is stepped to stepRelays once every 16 cycles
                    next_relayDrive = stepRelays;
                end
            end
            ST_STORE: begin
                storeEn = 1'b1;
                next_tuneHold = 1'b0;
                next_padRelay = 1'b0;
                next_ready = 1'b1;
                next_state = ST_SLEEP;
            end
            ST_RECALL: begin
                if (chMarker[chanIndex[6:0]] == VALID_MARK) begin
                    next_relayDrive = chSettings[chanIndex[6:0]];
                end
                next_state = ST_SLEEP;
            end
            ST_FAULT: begin
                next_fault = 1'b1;
                next_bypass = 1'b1;
                next_relayDrive = RELAY_RESET;
                next_tuneHold = 1'b0;
                next_padRelay = 1'b0;
                next_state = ST_SLEEP;
            end
            default: begin
                next_state = ST_SLEEP;
            end
        endcase
    end

    always_comb begin
        next_busOut = chanDriveEn ? channelLines_n : 8'h00;
    end

    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state <= ST_SLEEP;
            tuneTimer <= 36'h0;
            sampleCnt <= 10'h000;
            stepCnt <= 4'h0;
            chanSample <= 8'hff;
            tuneHold <= 1'b0;
            padRelay <= 1'b0;
            coupler_fault_flag <= 1'b0;
            bypass <= 1'b0;
            tuneReady <= 1'b0;
            relayDrive <= RELAY_RESET;
            muxedAddrDataOut <= 8'h00;
        end else begin
            state <= next_state;
            tuneTimer <= next_tuneTimer;
            sampleCnt <= next_sampleCnt;
            stepCnt <= next_stepCnt;
            chanSample <= next_chanSample;
            tuneHold <= next_tuneHold;
            padRelay <= next_padRelay;
            coupler_fault_flag <= next_fault;
            bypass <= next_bypass;
            tuneReady <= next_ready;
            relayDrive <= next_relayDrive;
            muxedAddrDataOut <= next_busOut;
        end
    end

    // nonvolatile store has no reset
    always_ff @(posedge core_clk) begin
        if (storeEn) begin
            chSettings[chanIndex[6:0]] <= relayDrive;
            chMarker[chanIndex[6:0]] <= VALID_MARK;
        end
    end

    assign muxedAddrDataOe = chanDriveEn;
    // asleep the bus is quiet
    assign busActive = (state != ST_SLEEP);

    tune_wake_a: assert property (@(posedge core_clk) disable iff (!rstSync_n)
        state == ST_SLEEP && tuneWake |=> state == ST_TUNE && tuneHold) else $error("no wake");
    hold_tune_a: assert property (@(posedge core_clk) disable iff (!rstSync_n)
        state == ST_TUNE |-> ##1 tuneHold) else $error("hold lost in tune");
    store_release_a: assert property (@(posedge core_clk) disable iff (!rstSync_n)
        state == ST_STORE |=> !tuneHold && !padRelay && state == ST_SLEEP)
        else $error("relays not released");
    sleep_quiet_a: assert property (@(posedge core_clk) disable iff (!rstSync_n)
        state == ST_SLEEP |-> !busActive) else $error("bus active asleep");
    fault_bypass_a: assert property (@(posedge core_clk) disable iff (!rstSync_n)
        state == ST_FAULT |=> coupler_fault_flag && bypass) else $error("fault missing");
    timeout_fault_a: assert property (@(posedge core_clk) disable iff (!rstSync_n)
        state == ST_TUNE && timeout && !tuneRequest && !front_tune_button
        |=> state == ST_FAULT ##1 coupler_fault_flag) else $error("timeout ignored");
    illegal_pair_a: assert property (@(posedge core_clk) disable iff (!rstSync_n)
        !impedance_high_n && !impedance_low_n |-> !magIn) else $error("illegal in window");
    recall_sleep_a: assert property (@(posedge core_clk) disable iff (!rstSync_n)
        state == ST_SLEEP && !tuneWake && chanChange |=> state == ST_RECALL ##1 state == ST_SLEEP)
        else $error("recall path broken");
    pad_in_a: assert property (@(posedge core_clk) disable iff (!rstSync_n)
        vswrFault && txKeyed && state != ST_STORE && state != ST_FAULT |=> padRelay)
        else $error("pad not in");
endmodule : atc_core

/* testbench/atc_partner.sv */
`timescale 1ns/1ps
module atc_partner (
    // clock
    input wire logic core_clk,
    // controller side and scenario mode
    input wire logic tuneHold,
    input wire logic [1:0] mode,
    // comparator and detector lines
    output logic impedance_high_n,
    output logic impedance_low_n,
    output logic phaseHigh_n,
    output logic phaseLow_n,
    output logic rfPresent_n
);
    logic [7:0] age = 8'h00;
    logic fit;
    logic bad;
    always_ff @(posedge core_clk) begin
        age <= !tuneHold ? 8'h00 : (age == 8'hff ? age : age + 8'h01);
    end
    // mode 0 settles after some relay steps, mode 1 never, mode 2 shows illegal pairs
    assign fit = (mode == 2'h0) && (age > 8'h28);
    assign bad = (mode == 2'h2);
    assign impedance_high_n = fit;
    assign impedance_low_n = fit | !bad;
    // outside mode 2, phase wanders from side to side while out of window until age saturates
    assign phaseHigh_n = fit | (!bad & age[2]);
    assign phaseLow_n = fit | (!bad & !age[2]);
    // carrier only while tune enable holds the exciter keyed
    assign rfPresent_n = !tuneHold;
endmodule : atc_partner

/* testbench/test_antenna_tune_controller.sv */
`timescale 1ns/1ps
module test_antenna_tune_controller;
    import atc_pkg::*;
    logic core_clk, rst_n, tuneRequest, front_tune_button, txKeyed, vswrFault, unitFailure;
    logic ale, readStrobe_n, impHighN, impLowN, phHighN, phLowN, rfN;
    logic [7:0] channelLines_n, muxedAddrDataIn, addrHigh, muxedAddrDataOut, chA;
    logic [15:0] stepRelays, relayDrive, goal, v1;
    logic [11:0] progAddr;
    logic [5:0] periphSelect;
    logic [1:0] mode;
    logic muxedAddrDataOe, progOe, tuneHold, padRelay, coupler_fault_flag, bypass;
    logic tuneReady, busActive;
    int err_total = 0;
    int n_compared = 0;
    int seed = 32'h13a67c94;

    atc_core #(.TUNE_LIMIT(200), .CHANNELS(128)) atc_core_inst (.core_clk(core_clk),
        .rst_n(rst_n), .tuneRequest(tuneRequest), .front_tune_button(front_tune_button),
        .channelLines_n(channelLines_n), .txKeyed(txKeyed), .rfPresent_n(rfN),
        .impedance_high_n(impHighN), .impedance_low_n(impLowN), .phaseHigh_n(phHighN),
        .phaseLow_n(phLowN), .vswrFault(vswrFault), .unitFailure(unitFailure),
        .stepRelays(stepRelays), .ale(ale), .muxedAddrDataIn(muxedAddrDataIn),
        .addrHigh(addrHigh), .readStrobe_n(readStrobe_n), .muxedAddrDataOut(muxedAddrDataOut),
        .muxedAddrDataOe(muxedAddrDataOe), .progAddr(progAddr), .progOe(progOe),
        .periphSelect(periphSelect), .tuneHold(tuneHold), .padRelay(padRelay),
        .coupler_fault_flag(coupler_fault_flag), .bypass(bypass), .tuneReady(tuneReady),
        .busActive(busActive), .relayDrive(relayDrive));
    atc_partner atc_partner_inst (.core_clk(core_clk), .tuneHold(tuneHold), .mode(mode),
        .impedance_high_n(impHighN), .impedance_low_n(impLowN), .phaseHigh_n(phHighN),
        .phaseLow_n(phLowN), .rfPresent_n(rfN));

    always #5 core_clk = ~core_clk;

    task complete_run;
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    function automatic logic pick(input int w);
        case (w)
            0: pick = tuneHold;
            1: pick = coupler_fault_flag;
            default: pick = (relayDrive === goal);
        endcase
    endfunction : pick

    // bounded wait; running out ends the run
    task automatic waitOn(input int w, input logic want, input int lim);
        int k;
        k = 0;
        while (pick(w) !== want && k < lim) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        chk("wait", pick(w), want);
        if (pick(w) !== want) begin
            complete_run;
        end
    endtask : waitOn

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc

    task doReset;
        @(posedge core_clk);
        rst_n <= 1'b0;
        cyc(5);
        @(posedge core_clk);
        rst_n <= 1'b1;
        cyc(3);
    endtask : doReset

    task tune;
        @(posedge core_clk);
        tuneRequest <= 1'b1;
        @(posedge core_clk);
        tuneRequest <= 1'b0;
        #1;
    endtask : tune

    function automatic logic [5:0] expSel(input logic [2:0] pg);
        expSel = (pg < 3'h6) ? (6'h01 << pg) : 6'h00;
    endfunction : expSel

    task automatic busCheck(input logic [7:0] hi, input logic [7:0] lo);
        @(posedge core_clk);
        ale <= 1'b1;
        addrHigh <= hi;
        muxedAddrDataIn <= lo;
        @(posedge core_clk);
        ale <= 1'b0;
        readStrobe_n <= 1'b0;
        muxedAddrDataIn <= ~lo;
        #1;
        chk("progAddr", progAddr, {hi[3:0], lo});
        chk("select", periphSelect, expSel(hi[7:5]));
        chk("progOe", progOe, hi[7:5] == 3'h0);
        chk("chanOe", muxedAddrDataOe, hi[7:5] == 3'h5);
        @(posedge core_clk);
        readStrobe_n <= 1'b1;
        #1;
        if (hi[7:5] == 3'h5) begin
            chk("chanData", muxedAddrDataOut, channelLines_n);
        end
        #1;
        chk("chanOeOff", muxedAddrDataOe, 1'b0);
    endtask : busCheck

    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        {tuneRequest, front_tune_button, txKeyed, vswrFault, unitFailure, ale} = 6'h00;
        readStrobe_n = 1'b1;
        mode = 2'h0;
        chA = $random(seed) & 8'h7f;
        channelLines_n = ~chA;
        stepRelays = $random(seed);
        muxedAddrDataIn = 8'h00;
        addrHigh = 8'h00;
        goal = 16'h0000;
        doReset;
        chk("resetDrive", relayDrive, RELAY_RESET);
        chk("resetHold", {tuneHold, coupler_fault_flag, bypass, padRelay}, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            addrHigh = $random(seed);
            busCheck({i[2:0], addrHigh[4:0]}, $random(seed));
        end
        // tune and store on channel A, then channel B, then recall A
        v1 = stepRelays;
        cyc(1100);
        tune;
        cyc(2);
        chk("holdOn", tuneHold, 1'b1);
        waitOn(0, 1'b0, 300);
        chk("ready", tuneReady, 1'b1);
        chk("quiet", {busActive, padRelay}, 16'h0000);
        chk("relays", relayDrive, v1);
        @(posedge core_clk);
        channelLines_n <= ~(chA ^ 8'h41);
        stepRelays <= ~v1;
        cyc(1100);
        tune;
        waitOn(0, 1'b0, 300);
        @(posedge core_clk);
        channelLines_n <= ~chA;
        goal = v1;
        waitOn(2, 1'b1, 1200);
        chk("recallHold", tuneHold, 1'b0);
        // illegal pairs must not end the tune
        mode <= 2'h2;
        tune;
        cyc(100);
        chk("illegal", tuneHold, 1'b1);
        mode <= 2'h0;
        waitOn(0, 1'b0, 300);
        // vswr fault wakes and pads while keyed
        txKeyed <= 1'b1;
        vswrFault <= 1'b1;
        waitOn(0, 1'b1, 5);
        cyc(3);
        chk("padIn", padRelay, 1'b1);
        cyc(60);
        vswrFault <= 1'b0;
        waitOn(0, 1'b0, 100);
        chk("padOut", padRelay, 1'b0);
        txKeyed <= 1'b0;
        front_tune_button <= 1'b1;
        cyc(1);
        front_tune_button <= 1'b0;
        waitOn(0, 1'b1, 5);
        waitOn(0, 1'b0, 300);
        // timeout with a restart in the middle
        mode <= 2'h1;
        tune;
        cyc(100);
        tune;
        cyc(180);
        chk("noFaultYet", coupler_fault_flag, 1'b0);
        waitOn(1, 1'b1, 40);
        chk("bypass", bypass, 1'b1);
        doReset;
        tune;
        cyc(5);
        unitFailure <= 1'b1;
        waitOn(1, 1'b1, 5);
        chk("bypassUnit", bypass, 1'b1);
        complete_run;
    end
endmodule : test_antenna_tune_controller
